// File: logic/control_transfer_privilege_check.sv
// control transfer privilege checker: near limit, far direct and gated checks
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/10ps
module control_transfer_privilege_check
   import xfer_priv_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic reqValid,
   input wire logic [1:0] reqKind,
   input wire logic reqIsCall,
   input wire logic [OFFSET_W-1:0] reqOffset,
   input wire logic [SEL_W-1:0] reqSelector,
   input wire logic targetIsGate,
   input wire logic [1:0] gateTable,
   input wire logic [PRIV_W-1:0] gatePriv,
   input wire logic [SEL_W-1:0] gateSelector,
   input wire logic [OFFSET_W-1:0] gateOffset,
   input wire logic codeIsExecutable,
   input wire logic codeConforming,
   input wire logic [PRIV_W-1:0] codePriv,
   input wire logic [OFFSET_W-1:0] codeLimit,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWdata,
   output logic [31:0] regRdata,
   output logic doneValid,
   output logic doneFault,
   output logic [OFFSET_W-1:0] doneOffset,
   output logic [SEL_W-1:0] codeSelector,
   output logic [PRIV_W-1:0] currentPriv,
   output logic irq
);

   // ------------------------------------------------------------
   // privilege helpers
   // ------------------------------------------------------------
   function automatic logic [PRIV_W-1:0] maxPriv(
      input logic [PRIV_W-1:0] a,
      input logic [PRIV_W-1:0] b);
      maxPriv = (a > b) ? a : b;
   endfunction

   function automatic logic directOk(
      input logic [PRIV_W-1:0] cur,
      input logic [PRIV_W-1:0] dst,
      input logic conf);
      directOk = (dst == cur) || (conf && dst < cur);
   endfunction

   function automatic logic atMost(
      input logic [PRIV_W-1:0] a,
      input logic [PRIV_W-1:0] b);
      atMost = (a <= b);
   endfunction

   // level field sits in the low bits of every selector
   function automatic logic [PRIV_W-1:0] levelOf(
      input logic [SEL_W-1:0] sel);
      levelOf = sel[SEL_RPL_LSB +: PRIV_W];
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [SEL_W-1:0] codeSel;
      logic [OFFSET_W-1:0] codeLim;
      // level of the running descriptor, kept apart from the current one
      logic [PRIV_W-1:0] execPriv;
      logic [IRQ_W-1:0] status;
      logic [IRQ_W-1:0] mask;
      logic [SEL_W-1:0] faultSel;
      logic [31:0] rdata;
      logic done;
      logic fault;
      logic [OFFSET_W-1:0] offset;
   } state_t;

   state_t cur;
   state_t next_s;

   // request decode
   logic isFar;
   logic [PRIV_W-1:0] reqLevel;
   logic [PRIV_W-1:0] curLevel;
   logic [PRIV_W-1:0] weakLevel;
   // gated path
   logic tableOk;
   logic gateLevelOk;
   logic sameLevel;
   logic notOutward;
   logic targetLevelOk;
   logic gateOk;
   // direct path
   logic directLevelOk;
   // limits and verdict
   logic farLimitOk;
   logic nearLimitOk;
   logic farOk;
   logic passOk;
   logic [SEL_W-1:0] destSel;
   logic [OFFSET_W-1:0] destOff;
   logic [PRIV_W-1:0] landLevel;
   logic [SEL_W-1:0] landSel;
   logic [IRQ_W-1:0] events;

   // ------------------------------------------------------------
   // register read decode
   // ------------------------------------------------------------
   // unmapped indices read as zero so software can probe safely
   function automatic logic [31:0] readWord(
      input logic [3:0] addr,
      input state_t s);
      readWord = 32'h0000_0000;
      unique case (addr)
         REG_STATUS: readWord = {30'h0000_0000, s.status};
         REG_MASK: readWord = {30'h0000_0000, s.mask};
         REG_CODE_SEL: readWord = {16'h0000, s.codeSel};
         REG_CODE_LIMIT: readWord = s.codeLim;
         REG_PRIV: readWord = {28'h000_0000, s.execPriv, levelOf(s.codeSel)};
         REG_FAULT_SEL: readWord = {16'h0000, s.faultSel};
         default: readWord = 32'h0000_0000;
      endcase
   endfunction

   // ------------------------------------------------------------
   // request decode
   // ------------------------------------------------------------
   // return and the spare kind code are near transfers
   always_comb begin
      isFar = (reqKind == KIND_FAR);
      curLevel = levelOf(cur.codeSel);
      reqLevel = levelOf(reqSelector);
      weakLevel = maxPriv(curLevel, reqLevel);
   end

   // ------------------------------------------------------------
   // gated check
   // ------------------------------------------------------------
   // a gate fetched through the interrupt table, or through the
   // unused table code, is never a legal call gate
   always_comb begin
      tableOk = 1'b0;
      unique case (gateTable)
         TABLE_GLOBAL: tableOk = 1'b1;
         TABLE_LOCAL: tableOk = 1'b1;
         TABLE_INTERRUPT: tableOk = 1'b0;
         default: tableOk = 1'b0;
      endcase
   end

   always_comb begin
      // the weaker of caller and selector must still reach the gate
      gateLevelOk = atMost(weakLevel, gatePriv);
      sameLevel = (codePriv == curLevel);
      notOutward = atMost(codePriv, curLevel);
      // only a call, or a jump into conforming code, may move inward;
      // nothing through a gate may move outward
      if (!reqIsCall && !codeConforming) begin
         targetLevelOk = sameLevel;
      end else begin
         targetLevelOk = notOutward;
      end
      gateOk = tableOk && gateLevelOk && targetLevelOk;
   end

   // ------------------------------------------------------------
   // direct check
   // ------------------------------------------------------------
   always_comb begin
      directLevelOk = directOk(curLevel, codePriv, codeConforming);
   end

   // ------------------------------------------------------------
   // destination and limits
   // ------------------------------------------------------------
   // the instruction offset is dropped on a gated transfer
   always_comb begin
      destSel = targetIsGate ? gateSelector : reqSelector;
      destOff = targetIsGate ? gateOffset : reqOffset;
      // new segment limit arrives with its fetched descriptor
      farLimitOk = (destOff <= codeLimit);
      // cached limit: a near check waits on no fetch
      nearLimitOk = (reqOffset <= cur.codeLim);
   end

   // ------------------------------------------------------------
   // verdict
   // ------------------------------------------------------------
   always_comb begin
      // a non-executable target faults whatever its levels
      farOk = 1'b0;
      if (codeIsExecutable) begin
         if (targetIsGate) begin
            farOk = gateOk;
         end else begin
            farOk = directLevelOk;
         end
      end
      if (isFar) begin
         passOk = farOk && farLimitOk;
      end else begin
         // no level check at all on a near transfer
         passOk = nearLimitOk;
      end
   end

   // ------------------------------------------------------------
   // landing selector
   // ------------------------------------------------------------
   // a conforming target runs at the caller's level, so the
   // selector's own level bits are not taken over
   always_comb begin
      if (codeConforming) begin
         landLevel = curLevel;
      end else begin
         landLevel = codePriv;
      end
      landSel = {destSel[SEL_W-1:PRIV_W], landLevel};
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_s = cur;
      next_s.done = 1'b0;
      next_s.rdata = 32'h0000_0000;
      events = '0;
      if (reqValid) begin
         next_s.done = 1'b1;
         next_s.fault = !passOk;
         next_s.offset = isFar ? destOff : reqOffset;
         events[IRQ_DONE_BIT] = 1'b1;
         if (!passOk) begin
            // code selector left alone on a fault
            events[IRQ_FAULT_BIT] = 1'b1;
            next_s.faultSel = destSel;
         end else if (isFar) begin
            next_s.codeLim = codeLimit;
            // may differ from the current level only when conforming
            next_s.execPriv = codePriv;
            next_s.codeSel = landSel;
         end
      end
      if (regWrite) begin
         unique case (regAddr)
            REG_STATUS: next_s.status = cur.status & ~regWdata[IRQ_W-1:0];
            REG_MASK: next_s.mask = regWdata[IRQ_W-1:0];
            default: ;
         endcase
      end
      // set wins over write-one-to-clear
      next_s.status = next_s.status | events;
      if (regRead) begin
         next_s.rdata = readWord(regAddr, cur);
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   // the core comes out of reset at the most privileged level
   always_ff @(posedge clock) begin
      if (srst) begin
         cur <= '0;
         cur.codeSel <= RESET_CODE_SEL;
         cur.codeLim <= RESET_CODE_LIMIT;
         cur.execPriv <= PRIV_MOST;
      end else begin
         cur <= next_s;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // fault only means something while the answer stands
   assign regRdata = cur.rdata;
   assign doneValid = cur.done;
   assign doneFault = cur.fault & cur.done;
   assign doneOffset = cur.offset;
   assign codeSelector = cur.codeSel;
   assign currentPriv = levelOf(cur.codeSel);
   assign irq = |(cur.status & cur.mask);

endmodule // control_transfer_privilege_check

// File: logic/xfer_priv_pkg.sv
// shared constants for the control transfer privilege checker
package xfer_priv_pkg;
   localparam int PRIV_W = 2;
   localparam int OFFSET_W = 32;
   localparam int SEL_W = 16;
   localparam int SEL_RPL_LSB = 0;
   localparam int SEL_TI_BIT = 2;
   localparam logic [1:0] PRIV_MOST = 2'h0;
   localparam logic [1:0] PRIV_LEAST = 2'h3;
   localparam logic [15:0] RESET_CODE_SEL = 16'h0000;
   localparam logic [31:0] RESET_CODE_LIMIT = 32'hFFFF_FFFF;
   // interrupt status / mask bit positions
   localparam int IRQ_FAULT_BIT = 0;
   localparam int IRQ_DONE_BIT = 1;
   localparam int IRQ_W = 2;
   // register indices on the plain port
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_MASK = 4'h1;
   localparam logic [3:0] REG_CODE_SEL = 4'h2;
   localparam logic [3:0] REG_CODE_LIMIT = 4'h3;
   localparam logic [3:0] REG_PRIV = 4'h4;
   localparam logic [3:0] REG_FAULT_SEL = 4'h5;
   localparam logic [1:0] KIND_NEAR = 2'h0;
   localparam logic [1:0] KIND_FAR = 2'h1;
   localparam logic [1:0] KIND_RETURN = 2'h2;
   localparam logic [1:0] TABLE_GLOBAL = 2'h0;
   localparam logic [1:0] TABLE_LOCAL = 2'h1;
   localparam logic [1:0] TABLE_INTERRUPT = 2'h2;
endpackage

// File: test/control_transfer_privilege_check_test.sv
// self-checking bench for the control transfer privilege checker
`timescale 1ns/10ps
module control_transfer_privilege_check_test
   import xfer_priv_pkg::*;
;
   typedef struct packed {
      logic [1:0] k;
      logic c;
      logic [31:0] off;
      logic [15:0] sel;
      logic flt;
      logic [15:0] cs;
   } row_t;
   localparam int NR = 14;
   // selector packs gate, levels, conforming, exec and table for the model
   row_t rows [NR] = '{'{KIND_FAR, 0, 'h100, 'h1000, 0, 'h1000},
      '{KIND_NEAR, 0, 'h1_0000, 0, 1, 'h1000},
      '{KIND_RETURN, 0, 'hFFFF, 0, 0, 'h1000}, '{3, 1, 'h1_0000, 0, 1, 'h1000},
      '{KIND_FAR, 0, 'h100, 'h1040, 1, 'h1000},
      '{KIND_FAR, 1, 'h100, 'h1140, 1, 'h1000},
      '{KIND_FAR, 0, 'h100, 'h1200, 1, 'h1000},
      '{KIND_FAR, 0, 'h100, 'h1103, 0, 'h1100},
      '{KIND_FAR, 0, 'h100, 'h2A, 0, 'h5000},
      '{KIND_FAR, 0, 'h100, 'h2B, 1, 'h5000},
      '{KIND_FAR, 0, 'h100, 'h6A, 1, 'h5000},
      '{KIND_FAR, 1, 'h100, 'h6A, 1, 'h5000},
      '{KIND_FAR, 1, 'h100, 'h82A, 1, 'h5000},
      '{KIND_FAR, 1, 'h100, 'h42A, 0, 'h5000}};
   logic clock = 0, srst = 1, reqValid = 0, reqIsCall = 0, regWrite = 0;
   logic regRead = 0, targetIsGate, codeIsExecutable, codeConforming;
   logic doneValid, doneFault, irq;
   logic [1:0] reqKind = 0, gateTable, gatePriv, codePriv, currentPriv;
   logic [31:0] reqOffset = 0, regWdata = 0, regRdata, doneOffset;
   logic [31:0] gateOffset, codeLimit;
   logic [15:0] reqSelector = 0, gateSelector, codeSelector;
   logic [3:0] regAddr = 0;
   int errorCnt = 0, nChecks = 0;
   control_transfer_privilege_check i_dut (.*);
   xfer_desc_model i_model (.*);
   always #5 clock = ~clock;
   task chk(input logic [31:0] s, input logic [31:0] e, input string m);
      nChecks++;
      if (s !== e) begin
         errorCnt++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      {regWrite, regAddr, regWdata} <= {1'b1, a, d};
      @(posedge clock);
      regWrite <= 0;
   endtask
   task rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clock);
      {regRead, regAddr} <= {1'b1, a};
      @(posedge clock);
      regRead <= 0;
      #1 chk(regRdata, e, "read");
   endtask
   task giveVerdict;
      $display("checks %0d errors %0d", nChecks, errorCnt);
      if (errorCnt == 0 && nChecks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      #20000 errorCnt++;
      giveVerdict;
   end
   initial begin
      repeat (12) @(posedge clock);
      srst <= 0;
      rd(REG_CODE_LIMIT, 32'hFFFF_FFFF);
      wr(REG_MASK, 1);
      // back to back: each answer but the last is checked while the next request is up
      for (int i = 0; i <= NR; i++) begin
         @(posedge clock);
         reqValid <= i < NR;
         if (i < NR)
            {reqKind, reqIsCall, reqOffset, reqSelector} <= rows[i][67:17];
         #1;
         if (i > 0) begin
            chk(doneValid, 1, "answer");
            chk(doneFault, rows[i-1].flt, "fault");
            chk(codeSelector, rows[i-1].cs, "code");
            if (!rows[i-1].flt)
               chk(doneOffset, rows[i-1].sel[3] ? 32'h40 : rows[i-1].off,
                  "offset");
         end
      end
      chk(irq, 1, "irq on");
      rd(REG_CODE_LIMIT, 32'hFFFF);
      wr(REG_STATUS, 1);
      rd(REG_STATUS, 2);
      chk(irq, 0, "irq off");
      rd(4'hF, 0);
      srst <= 1;
      repeat (2) @(posedge clock);
      srst <= 0;
      rd(REG_CODE_LIMIT, 32'hFFFF_FFFF);
      chk(codeSelector, 0, "code reset");
      giveVerdict;
   end
endmodule // control_transfer_privilege_check_test
bind control_transfer_privilege_check xfer_priv_sva i_sva (.*);

// File: test/xfer_desc_model.sv
// descriptor fetch model: gate, level, conforming, exec and table fields decoded from the test selector; gate target and limit fixed
`timescale 1ns/10ps
module xfer_desc_model
   import xfer_priv_pkg::*;
(
   input wire logic [SEL_W-1:0] reqSelector,
   output logic targetIsGate,
   output logic [1:0] gateTable,
   output logic [PRIV_W-1:0] gatePriv,
   output logic [SEL_W-1:0] gateSelector,
   output logic [OFFSET_W-1:0] gateOffset,
   output logic codeIsExecutable,
   output logic codeConforming,
   output logic [PRIV_W-1:0] codePriv,
   output logic [OFFSET_W-1:0] codeLimit
);
   assign targetIsGate = reqSelector[3];
   assign gateTable = reqSelector[11:10];
   assign gatePriv = reqSelector[5:4];
   assign gateSelector = 16'h5000;
   assign gateOffset = 32'h40;
   assign codeIsExecutable = !reqSelector[9];
   assign codeConforming = reqSelector[8];
   assign codePriv = reqSelector[7:6];
   assign codeLimit = 32'hFFFF;
endmodule // xfer_desc_model

// File: test/xfer_priv_sva.sv
// port assertions for the control transfer privilege checker
`timescale 1ns/10ps
module xfer_priv_sva
   import xfer_priv_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic reqValid,
   input wire logic [1:0] reqKind,
   input wire logic [OFFSET_W-1:0] reqOffset,
   input wire logic doneValid,
   input wire logic doneFault,
   input wire logic [OFFSET_W-1:0] doneOffset,
   input wire logic [SEL_W-1:0] codeSelector,
   input wire logic [PRIV_W-1:0] currentPriv
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   a_answer_next: assert property (reqValid |=> doneValid)
      else $error("no answer");
   a_no_stray: assert property (!reqValid |=> !doneValid)
      else $error("stray answer");
   a_fault_qual: assert property (doneFault |-> doneValid)
      else $error("fault alone");
   a_priv_bits: assert property (currentPriv == codeSelector[1:0])
      else $error("level not selector bits");
   a_near_keep: assert property (reqValid && reqKind != KIND_FAR
      |=> $stable(codeSelector)) else $error("near moved code");
   a_near_offset: assert property (reqValid && reqKind != KIND_FAR
      |=> doneFault || doneOffset == $past(reqOffset))
      else $error("near offset");
   a_fault_keep: assert property (doneValid && doneFault
      |-> $stable(codeSelector)) else $error("fault moved code");
   a_sel_quiet: assert property (!doneValid && !$past(srst)
      |-> $stable(codeSelector)) else $error("code moved idle");
endmodule // xfer_priv_sva
